// ==== hdl/rcs_top.sv ====
// reset cause status register with axi4-lite slave and interrupt
`include "rcs_map.svh"
module rcs_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire rcs_pkg::rcs_events_t cause_events,
    output logic regulator_sleep_keep_on,
    output logic irq,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import rcs_pkg::*;

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic [1:0] reg_idx(input logic [3:0] a);
        reg_idx = a[3:2];
    endfunction

    // ==========================================
    // event vector
    logic [31:0] set_vec;
    always_comb begin
        set_vec = 32'h00000000;
        set_vec[`RCS_BIT_HV] = cause_events.high_voltage;
        set_vec[`RCS_BIT_CM] = cause_events.config_mismatch;
        set_vec[`RCS_BIT_PIN] = cause_events.master_clear_pin;
        set_vec[`RCS_BIT_SW] = cause_events.soft_reset;
        set_vec[`RCS_BIT_WDT] = cause_events.watchdog_expired;
        set_vec[`RCS_BIT_SLEEP] = cause_events.sleep_wake;
        set_vec[`RCS_BIT_IDLE] = cause_events.idle_wake;
        set_vec[`RCS_BIT_BOR] = cause_events.brownout;
        set_vec[`RCS_BIT_POR] = cause_events.power_on;
    end

    // ==========================================
    // write channel
    logic [3:0] aw_addr_r;
    logic aw_have_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_have_r;
    logic wr_fire;
    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready = !w_have_r && !s_axi_bvalid;
    assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_r <= 1'b0;
        end
    end

    logic wr_status, wr_mask_reg, wr_known;
    assign wr_status = wr_fire && (reg_idx(aw_addr_r) == reg_idx(`RCS_OFF_STATUS));
    assign wr_mask_reg = wr_fire && (reg_idx(aw_addr_r) == reg_idx(`RCS_OFF_IRQ_MASK));
    always_comb begin
        if (reg_idx(aw_addr_r) == reg_idx(`RCS_OFF_STATUS)) begin
            wr_known = 1'b1;
        end else if (reg_idx(aw_addr_r) == reg_idx(`RCS_OFF_IRQ_STAT)) begin
            wr_known = 1'b1;
        end else if (reg_idx(aw_addr_r) == reg_idx(`RCS_OFF_IRQ_MASK)) begin
            wr_known = 1'b1;
        end else begin
            wr_known = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RCS_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `RCS_RESP_OKAY : `RCS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================
    // read channel
    rcs_rd_state_t rd_state_r;
    logic rd_fire;
    assign s_axi_arready = (rd_state_r == RCS_RD_IDLE);
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    logic rd_irq_stat;
    assign rd_irq_stat = rd_fire && (reg_idx(s_axi_araddr) == reg_idx(`RCS_OFF_IRQ_STAT));

    // ==========================================
    // registers
    logic [31:0] status_val, irq_stat_val, irq_mask_r;
    rcs_flag_reg #(
        .WIDTH(32),
        .RESET_VAL(`RCS_RESET_VAL),
        .IMPL(`RCS_IMPL_MASK)
    ) u_status (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_bits(set_vec),
        .wr_en(wr_status),
        .wr_data(w_data_r),
        .wr_mask(strb_mask(w_strb_r)),
        .clr_en(1'b0),
        .value(status_val)
    );
    assign regulator_sleep_keep_on = status_val[`RCS_BIT_VREG];

    rcs_flag_reg #(
        .WIDTH(32),
        .RESET_VAL(32'h00000000),
        .IMPL(`RCS_FLAG_MASK)
    ) u_irq_stat (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_bits(set_vec),
        .wr_en(1'b0),
        .wr_data(32'h00000000),
        .wr_mask(32'h00000000),
        .clr_en(rd_irq_stat),
        .value(irq_stat_val)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_r <= 32'h00000000;
        end else if (wr_mask_reg) begin
            irq_mask_r <= ((irq_mask_r & ~strb_mask(w_strb_r)) | (w_data_r & strb_mask(w_strb_r))) & `RCS_FLAG_MASK;
        end
    end
    assign irq = |(irq_stat_val & irq_mask_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_r <= RCS_RD_IDLE;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RCS_RESP_OKAY;
        end else begin
            case (rd_state_r)
                RCS_RD_IDLE: begin
                    if (rd_fire) begin
                        rd_state_r <= RCS_RD_RESP;
                        s_axi_rresp <= `RCS_RESP_OKAY;
                        if (reg_idx(s_axi_araddr) == reg_idx(`RCS_OFF_STATUS)) begin
                            s_axi_rdata <= status_val & `RCS_IMPL_MASK;
                        end else if (reg_idx(s_axi_araddr) == reg_idx(`RCS_OFF_IRQ_STAT)) begin
                            s_axi_rdata <= irq_stat_val;
                        end else if (reg_idx(s_axi_araddr) == reg_idx(`RCS_OFF_IRQ_MASK)) begin
                            s_axi_rdata <= irq_mask_r;
                        end else begin
                            s_axi_rdata <= 32'h00000000;
                            s_axi_rresp <= `RCS_RESP_SLVERR;
                        end
                    end
                end
                RCS_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_r <= RCS_RD_IDLE;
                    end
                end
                default: begin
                    rd_state_r <= RCS_RD_IDLE;
                end
            endcase
        end
    end
    assign s_axi_rvalid = (rd_state_r == RCS_RD_RESP);

    // ==========================================
    // checks
    property p_hv_set;
        @(posedge aclk) disable iff (!aresetn) cause_events.high_voltage |=> status_val[`RCS_BIT_HV];
    endproperty
    a_hv_set: assert property (p_hv_set) else $error("hv flag not set");
    property p_cm_set;
        @(posedge aclk) disable iff (!aresetn) cause_events.config_mismatch |=> status_val[`RCS_BIT_CM];
    endproperty
    a_cm_set: assert property (p_cm_set) else $error("cm flag not set");
    property p_vreg_wr;
        @(posedge aclk) disable iff (!aresetn)
            wr_status && w_strb_r[1] |=> regulator_sleep_keep_on == $past(w_data_r[`RCS_BIT_VREG]);
    endproperty
    a_vreg_wr: assert property (p_vreg_wr) else $error("regulator bit not written");
    property p_vreg_hold;
        @(posedge aclk) disable iff (!aresetn) !wr_status |=> $stable(regulator_sleep_keep_on);
    endproperty
    a_vreg_hold: assert property (p_vreg_hold) else $error("regulator bit moved without write");
    property p_reset_val;
        @(posedge aclk) disable iff (!aresetn) !$past(aresetn) |-> status_val == `RCS_RESET_VAL;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("status wrong after reset");
    property p_pin_set;
        @(posedge aclk) disable iff (!aresetn) cause_events.master_clear_pin |=> status_val[`RCS_BIT_PIN];
    endproperty
    a_pin_set: assert property (p_pin_set) else $error("pin flag not set");
    property p_sw_set;
        @(posedge aclk) disable iff (!aresetn) cause_events.soft_reset |=> status_val[`RCS_BIT_SW];
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("sw flag not set");
    property p_wdt_set;
        @(posedge aclk) disable iff (!aresetn) cause_events.watchdog_expired |=> status_val[`RCS_BIT_WDT];
    endproperty
    a_wdt_set: assert property (p_wdt_set) else $error("wdt flag not set");
    property p_sleep_set;
        @(posedge aclk) disable iff (!aresetn) cause_events.sleep_wake |=> status_val[`RCS_BIT_SLEEP];
    endproperty
    a_sleep_set: assert property (p_sleep_set) else $error("sleep flag not set");
    property p_idle_set;
        @(posedge aclk) disable iff (!aresetn) cause_events.idle_wake |=> status_val[`RCS_BIT_IDLE];
    endproperty
    a_idle_set: assert property (p_idle_set) else $error("idle flag not set");
    property p_bor_set;
        @(posedge aclk) disable iff (!aresetn) cause_events.brownout |=> status_val[`RCS_BIT_BOR];
    endproperty
    a_bor_set: assert property (p_bor_set) else $error("bor flag not set");
    property p_por_set;
        @(posedge aclk) disable iff (!aresetn) cause_events.power_on |=> status_val[`RCS_BIT_POR];
    endproperty
    a_por_set: assert property (p_por_set) else $error("por flag not set");
    property p_sticky;
        @(posedge aclk) disable iff (!aresetn) (!wr_status && $past(aresetn)) |=> ((status_val & $past(status_val)) == $past(status_val));
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without write");
    property p_unimpl;
        @(posedge aclk) disable iff (!aresetn) (status_val & ~`RCS_IMPL_MASK) == 32'h00000000;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
    property p_set_wins;
        @(posedge aclk) disable iff (!aresetn)
            wr_status && (set_vec != 32'h00000000) |=> ((status_val & $past(set_vec)) == $past(set_vec));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to write");
    property p_wr_takes;
        @(posedge aclk) disable iff (!aresetn) wr_status && (w_strb_r == 4'hf) && (set_vec == 32'h00000000)
            |=> status_val == ($past(w_data_r) & `RCS_IMPL_MASK);
    endproperty
    a_wr_takes: assert property (p_wr_takes) else $error("status write not applied");

    // ==========================================
    // interrupt checks
    property p_irq;
        @(posedge aclk) disable iff (!aresetn) (|(set_vec & irq_mask_r)) && !wr_mask_reg |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked event gave no irq");
    property p_irq_clear;
        @(posedge aclk) disable iff (!aresetn) rd_irq_stat && (set_vec == 32'h00000000) |=> !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq stays after status read");
    property p_irq_stat_sticky;
        @(posedge aclk) disable iff (!aresetn)
            !rd_irq_stat |=> ((irq_stat_val & $past(irq_stat_val)) == $past(irq_stat_val));
    endproperty
    a_irq_stat_sticky: assert property (p_irq_stat_sticky) else $error("irq status dropped without read");
    property p_mask_wr;
        @(posedge aclk) disable iff (!aresetn)
            wr_mask_reg && (w_strb_r == 4'hf) |=> irq_mask_r == ($past(w_data_r) & `RCS_FLAG_MASK);
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write not applied");
    property p_mask_impl;
        @(posedge aclk) disable iff (!aresetn) (irq_mask_r & ~`RCS_FLAG_MASK) == 32'h00000000;
    endproperty
    a_mask_impl: assert property (p_mask_impl) else $error("mask holds a bit without a flag");

    // ==========================================
    // bus checks
    sequence s_wr_commit;
        wr_fire;
    endsequence
    sequence s_wr_answer;
        s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endsequence
    property p_wr_resp;
        @(posedge aclk) disable iff (!aresetn) s_wr_commit |=> s_wr_answer;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
    property p_b_drop;
        @(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_drop: assert property (p_b_drop) else $error("write response not released");
    property p_wr_okay;
        @(posedge aclk) disable iff (!aresetn) wr_fire && wr_known |=> s_axi_bresp == `RCS_RESP_OKAY;
    endproperty
    a_wr_okay: assert property (p_wr_okay) else $error("mapped write not okay");
    property p_wr_slverr;
        @(posedge aclk) disable iff (!aresetn) wr_fire && !wr_known |=> s_axi_bresp == `RCS_RESP_SLVERR;
    endproperty
    a_wr_slverr: assert property (p_wr_slverr) else $error("unmapped write not refused");
    sequence s_rd_take;
        rd_fire;
    endsequence
    sequence s_rd_answer;
        s_axi_rvalid && !s_axi_arready;
    endsequence
    property p_rd_resp;
        @(posedge aclk) disable iff (!aresetn) s_rd_take |=> s_rd_answer;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read response missing");
    property p_r_drop;
        @(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_drop: assert property (p_r_drop) else $error("read response not released");
    property p_rd_status;
        @(posedge aclk) disable iff (!aresetn)
            rd_fire && (reg_idx(s_axi_araddr) == reg_idx(`RCS_OFF_STATUS)) |=> s_axi_rdata == $past(status_val);
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read data wrong");
    property p_rd_irq;
        @(posedge aclk) disable iff (!aresetn) rd_irq_stat |=> s_axi_rdata == $past(irq_stat_val);
    endproperty
    a_rd_irq: assert property (p_rd_irq) else $error("irq status read data wrong");
    property p_rd_mask;
        @(posedge aclk) disable iff (!aresetn)
            rd_fire && (reg_idx(s_axi_araddr) == reg_idx(`RCS_OFF_IRQ_MASK)) |=> s_axi_rdata == $past(irq_mask_r);
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("mask read data wrong");
    property p_rd_unmapped;
        @(posedge aclk) disable iff (!aresetn) rd_fire && (reg_idx(s_axi_araddr) == 2'h3)
            |=> (s_axi_rresp == `RCS_RESP_SLVERR) && (s_axi_rdata == 32'h00000000);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
endmodule

// ==== hdl/rcs_map.svh ====
// register offsets, field positions, reset values and bus constants for the reset cause status block
// Behaviour
// - high-voltage reset sets bit 29, cleared at power-on
// - configuration mismatch reset sets bit 9
// - bit 8 keeps regulator on in sleep
// - master clear pin reset sets bit 7
// - software reset sets bit 6
// - watchdog expiry sets bit 4
// - sleep wake sets bit 3
// - idle wake sets bit 2
// - brown-out sets bit 1, one after power-on
// - power-on sets bit 0, one after power-on
// - flags sticky until software clears them
// - unimplemented bits read zero, ignore writes
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH
// ==========================================
// offsets
`define RCS_OFF_STATUS 4'h0
`define RCS_OFF_IRQ_STAT 4'h4
`define RCS_OFF_IRQ_MASK 4'h8
// ==========================================
// field positions
`define RCS_BIT_HV 29
`define RCS_BIT_CM 9
`define RCS_BIT_VREG 8
`define RCS_BIT_PIN 7
`define RCS_BIT_SW 6
`define RCS_BIT_WDT 4
`define RCS_BIT_SLEEP 3
`define RCS_BIT_IDLE 2
`define RCS_BIT_BOR 1
`define RCS_BIT_POR 0
// ==========================================
// masks and reset values
`define RCS_IMPL_MASK 32'h200003df
`define RCS_FLAG_MASK 32'h200002df
`define RCS_RESET_VAL 32'h00000003
`define RCS_RESP_OKAY 2'b00
`define RCS_RESP_SLVERR 2'b10
`endif

// ==== hdl/rcs_pkg.sv ====
// types shared by the reset cause status block
package rcs_pkg;
    typedef struct packed {
        logic high_voltage;
        logic config_mismatch;
        logic master_clear_pin;
        logic soft_reset;
        logic watchdog_expired;
        logic sleep_wake;
        logic idle_wake;
        logic brownout;
        logic power_on;
    } rcs_events_t;
    typedef enum logic [1:0] {RCS_RD_IDLE, RCS_RD_RESP} rcs_rd_state_t;
endpackage

// ==== hdl/rcs_flag_reg.sv ====
// sticky flag register with hardware set priority
`include "rcs_map.svh"
module rcs_flag_reg #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] RESET_VAL = '0,
    parameter logic [WIDTH-1:0] IMPL = '1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] set_bits,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [WIDTH-1:0] wr_mask,
    input wire logic clr_en,
    output logic [WIDTH-1:0] value
);
    logic [WIDTH-1:0] value_nxt;
    always_comb begin
        value_nxt = value;
        if (wr_en) begin
            value_nxt = (value & ~wr_mask) | (wr_data & wr_mask);
        end
        if (clr_en) begin
            value_nxt = '0;
        end
        value_nxt = (value_nxt | set_bits) & IMPL;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value <= RESET_VAL;
        end else begin
            value <= value_nxt;
        end
    end
endmodule

// ==== tb/reset_cause_status_register_tb.sv ====
// self-checking bench for the reset cause status register block
module reset_cause_status_register_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rcs_pkg::*;
    logic aclk, aresetn, regulator_sleep_keep_on, irq;
    rcs_events_t cause_events;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int err_count = 0;
    int num_checks = 0;
    int pos [9] = '{0, 1, 2, 3, 4, 6, 7, 9, 29};
    rcs_events_t wr_ev = '0;

    rcs_top u_rcs_top (.aclk(aclk), .aresetn(aresetn), .cause_events(cause_events),
        .regulator_sleep_keep_on(regulator_sleep_keep_on), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // ==========================================
    // reporting
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic hang(input string msg);
        err_count++;
        $display("wrong value at %0t: %s timed out", $time, msg);
        test_done();
    endtask

    // ==========================================
    // bus cycles, entered and left just after a rising edge
    // wr_ev is driven for the one cycle in which the taken write is applied
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r);
        int n;
        logic got, aw_done, w_done, ev_sent;
        n = 0;
        got = 1'b0;
        aw_done = 1'b0;
        w_done = 1'b0;
        ev_sent = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w_done = 1'b1;
            end
            if (ev_sent) begin
                cause_events <= '0;
            end else if (aw_done && w_done) begin
                cause_events <= wr_ev;
                ev_sent = 1'b1;
            end
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                got = 1'b1;
            end
            if (!got && n == 50) hang("write");
        end
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                got = 1'b1;
            end
            if (!got && n == 50) hang("read");
        end
        @(posedge aclk);
    endtask

    task automatic pulse(input rcs_events_t ev);
        cause_events <= ev;
        @(posedge aclk);
        cause_events <= '0;
        @(posedge aclk);
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        axi_rd(4'h0, rd, rs);
        chk(rd, 32'h00000003, "status after reset");
        chk({30'h0, rs}, 32'h0, "status read response");
        axi_rd(4'h8, rd, rs);
        chk(rd, 32'h00000000, "mask after reset");
        chk({31'h0, irq}, 32'h0, "irq after reset");
    endtask

    task automatic t_clear_and_regulator();
        axi_wr(4'h0, 32'h00000000, 4'hf, rs);
        chk({30'h0, rs}, 32'h0, "status write response");
        axi_rd(4'h0, rd, rs);
        chk(rd, 32'h00000000, "flags cleared by software");
        axi_wr(4'h0, 32'h00000100, 4'hf, rs);
        chk({31'h0, regulator_sleep_keep_on}, 32'h1, "regulator kept on");
        axi_rd(4'h0, rd, rs);
        chk(rd, 32'h00000100, "regulator bit reads back");
        axi_wr(4'h0, 32'h00000000, 4'hf, rs);
        chk({31'h0, regulator_sleep_keep_on}, 32'h0, "regulator off in sleep");
    endtask

    task automatic t_events();
        for (int i = 0; i < 9; i++) begin
            axi_wr(4'h0, 32'h00000000, 4'hf, rs);
            pulse(rcs_events_t'(9'h001 << i));
            axi_rd(4'h0, rd, rs);
            chk(rd, 32'h1 << pos[i], "event flag set");
            axi_rd(4'h0, rd, rs);
            chk(rd, 32'h1 << pos[i], "event flag sticky");
        end
    endtask

    task automatic t_unimplemented();
        axi_wr(4'h0, 32'hffffffff, 4'hf, rs);
        axi_rd(4'h0, rd, rs);
        chk(rd, 32'h200003df, "only implemented bits written");
        axi_wr(4'h0, 32'h00000000, 4'h2, rs);
        axi_rd(4'h0, rd, rs);
        chk(rd, 32'h200000df, "byte lane one cleared only");
        axi_wr(4'h8, 32'hffffffff, 4'hf, rs);
        axi_rd(4'h8, rd, rs);
        chk(rd, 32'h200002df, "mask writable bits");
        axi_wr(4'h8, 32'h00000000, 4'hf, rs);
        axi_wr(4'h0, 32'h00000000, 4'hf, rs);
    endtask

    task automatic t_set_beats_clear();
        axi_wr(4'h0, 32'h200002df, 4'hf, rs);
        wr_ev = rcs_events_t'(9'h002);
        axi_wr(4'h0, 32'h00000000, 4'hf, rs);
        wr_ev = '0;
        axi_rd(4'h0, rd, rs);
        chk(rd, 32'h00000002, "hardware set wins over clear");
    endtask

    task automatic t_irq();
        axi_rd(4'h4, rd, rs);
        axi_wr(4'h8, 32'h00000080, 4'hf, rs);
        pulse(9'h040);
        chk({31'h0, irq}, 32'h1, "unmasked event raises irq");
        axi_rd(4'h4, rd, rs);
        chk(rd, 32'h00000080, "irq status bit");
        chk({31'h0, irq}, 32'h0, "read clears irq");
        axi_rd(4'h4, rd, rs);
        chk(rd, 32'h00000000, "irq status cleared");
        pulse(9'h010);
        chk({31'h0, irq}, 32'h0, "masked event keeps irq low");
        axi_rd(4'h4, rd, rs);
        chk(rd, 32'h00000010, "masked event still recorded");
    endtask

    task automatic t_unmapped();
        axi_wr(4'hc, 32'hffffffff, 4'hf, rs);
        chk({30'h0, rs}, 32'h2, "unmapped write response");
        axi_rd(4'h0, rd, rs);
        chk(rd, 32'h00000092, "unmapped write ignored");
        axi_rd(4'hc, rd, rs);
        chk({30'h0, rs}, 32'h2, "unmapped read response");
        chk(rd, 32'h00000000, "unmapped read data");
    endtask

    task automatic t_rereset();
        axi_wr(4'h8, 32'h00000080, 4'hf, rs);
        axi_wr(4'h0, 32'h20000100, 4'hf, rs);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({31'h0, regulator_sleep_keep_on}, 32'h0, "regulator off after reset");
        axi_rd(4'h0, rd, rs);
        chk(rd, 32'h00000003, "status after second reset");
        axi_rd(4'h8, rd, rs);
        chk(rd, 32'h00000000, "mask after second reset");
    endtask

    initial begin
        aresetn = 1'b0;
        cause_events = '0;
        {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_clear_and_regulator();
        t_events();
        t_unimplemented();
        t_set_beats_clear();
        t_irq();
        t_unmapped();
        t_rereset();
        test_done();
    end
endmodule
